//--- hdl/dac_pkg.sv
// Purpose: Shared constants and types for the DDR3 memory access core.
// Assumes: x8 organisation, one 100 MHz system clock that samples all pins.
// Notes: Storage is a small flip-flop array, so rows and columns alias.
//
// Notes on behaviour
// - Each burst is one eight-word core transfer, shifted out two words per clock.
// - Memory drives the strobe with read data, edges aligned to data changes.
// - Command, control and address are taken on each true positive clock crossing.
// - First write or read word belongs to the first strobe rise after preamble.
// - Bursts start at the chosen column and follow the programmed length and order.
// - Activate uses its sampled bank and address to pick bank and row.
// - Read and write use sampled bank and address for bank and start column.
// - Bursts are eight beats, or four when chopped by mode or per command.
// - Auto precharge closes the row by itself when the burst completes.
// - Eight independent banks may be opened and closed concurrently.
// - Row address is fifteen bits wide for this organisation.
// - Read and write latency are programmable, plus a posted additive latency.
// - Self refresh and power-down states are provided.
// - Normal operation assumes the delay-locked loop is enabled.
// - With per-command chop, address bit 12 high means eight beats, low four.
// - Commands are ignored while chip select is sampled high.
// - Precharge with address bit 10 low closes one bank, high closes all.

package dac_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DAC_ROW_W = 15;
  localparam int DAC_BANK_W = 3;
  localparam int DAC_BANKS = 8;
  localparam int DAC_DQ_W = 8;
  localparam int DAC_PREFETCH = 8;
  localparam int DAC_MEM_W = 7;
  localparam int DAC_MEM_WORDS = 128;
  localparam int DAC_AP_BIT = 10;
  localparam int DAC_BC_BIT = 12;

  // ----------------------------------------------------------------
  // Pin groups
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [DAC_BANK_W-1:0] ba;
    logic [DAC_ROW_W-1:0] addr;
  } dac_cmd_t;

  typedef struct packed {
    logic [DAC_DQ_W-1:0] dq;
    logic dm;
    logic dqs;
    logic dqs_n;
  } dac_din_t;

  typedef struct packed {
    logic [DAC_DQ_W-1:0] dq;
    logic dq_oe;
    logic dqs;
    logic dqs_n;
    logic dqs_oe;
  } dac_dout_t;

  // Command code is {ras_n, cas_n, we_n}.
  localparam logic [2:0] DAC_OP_MODE = 3'h0;
  localparam logic [2:0] DAC_OP_REF = 3'h1;
  localparam logic [2:0] DAC_OP_PRE = 3'h2;
  localparam logic [2:0] DAC_OP_ACT = 3'h3;
  localparam logic [2:0] DAC_OP_WR = 3'h4;
  localparam logic [2:0] DAC_OP_RD = 3'h5;

  typedef enum logic [1:0] {DAC_PW_ACTIVE, DAC_PW_DOWN, DAC_PW_SELF} dac_pwr_t;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int DAC_RA_W = 4;
  localparam int DAC_RD_W = 16;
  localparam logic [3:0] DAC_REG_MODE = 4'h0;
  localparam logic [3:0] DAC_REG_STATUS = 4'h1;
  localparam logic [3:0] DAC_REG_REFCNT = 4'h2;
  localparam logic [15:0] DAC_MODE_RST = 16'h8056;
  localparam int DAC_CL_LSB = 0;
  localparam int DAC_CWL_LSB = 4;
  localparam int DAC_AL_LSB = 8;
  localparam int DAC_BM_LSB = 12;
  localparam int DAC_ORDER_BIT = 14;
  localparam int DAC_DLL_BIT = 15;
  localparam logic [1:0] DAC_BM_BL8 = 2'h0;
  localparam logic [1:0] DAC_BM_BC4 = 2'h1;
  localparam logic [1:0] DAC_BM_PERCMD = 2'h2;
  localparam logic [3:0] DAC_LEN_BL8 = 4'h8;
  localparam logic [3:0] DAC_LEN_BC4 = 4'h4;
  localparam int DAC_ST_PWR_LSB = 8;
  localparam int DAC_ST_RD_BIT = 10;
  localparam int DAC_ST_WR_BIT = 11;
  localparam int DAC_ST_DLL_BIT = 12;

endpackage

//--- hdl/dac_sync.sv
// Purpose: Two-stage synchroniser for a group of pin inputs.
// Assumes: Bits of the group are stable around the edges that matter.
// Notes: Only the second stage may be read by other logic.

module dac_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end

endmodule

//--- hdl/dac_core.sv
// Purpose: DDR3 memory device core: command decode, banks, burst engines.
// Assumes: Pins sampled by MCLK_IN; pin clock far slower than MCLK_IN.
// Notes: One read and one write burst in flight at a time.

module dac_core
  import dac_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic CK_IN,
  input wire logic CK_N_IN,
  input wire dac_cmd_t CMD_IN,
  input wire dac_din_t DATA_IN,
  output dac_dout_t DATA_OUT,
  input wire logic [DAC_RA_W-1:0] REG_ADDR_IN,
  input wire logic [DAC_RD_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [DAC_RD_W-1:0] REG_RDATA_OUT
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] ck_s;
  dac_cmd_t cmd_s;
  dac_din_t din_s;
  logic ck_prev_reg;
  logic dqs_prev_reg;
  logic ck_hi;
  logic ck_pos;
  logic ck_neg;
  logic dqs_hi;
  logic dqs_rise;
  logic dqs_fall;

  dac_sync #(.W(2)) u_ck_sync (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .d_in({CK_IN, CK_N_IN}),
    .q_out(ck_s)
  );

  dac_sync #(.W($bits(dac_cmd_t))) u_cmd_sync (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .d_in(CMD_IN),
    .q_out(cmd_s)
  );

  dac_sync #(.W($bits(dac_din_t))) u_din_sync (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .d_in(DATA_IN),
    .q_out(din_s)
  );

  // A positive edge needs the true clock high and the complement low.
  assign ck_hi = ck_s[1] & ~ck_s[0];
  assign ck_pos = ck_hi & ~ck_prev_reg;
  assign ck_neg = ~ck_hi & ck_prev_reg;
  assign dqs_hi = din_s.dqs & ~din_s.dqs_n;
  assign dqs_rise = dqs_hi & ~dqs_prev_reg;
  assign dqs_fall = ~dqs_hi & dqs_prev_reg;

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      ck_prev_reg <= 1'b0;
      dqs_prev_reg <= 1'b0;
    end else begin
      ck_prev_reg <= ck_hi;
      dqs_prev_reg <= dqs_hi;
    end
  end

  // ----------------------------------------------------------------
  // Mode register and derived settings
  // ----------------------------------------------------------------
  logic [15:0] mode_reg;
  logic [4:0] rl;
  logic [4:0] wl;
  logic [1:0] bmode;
  logic order_il;
  logic dll_on;

  assign rl = {1'b0, mode_reg[DAC_AL_LSB +: 4]} +
              {1'b0, mode_reg[DAC_CL_LSB +: 4]};
  assign wl = {1'b0, mode_reg[DAC_AL_LSB +: 4]} +
              {1'b0, mode_reg[DAC_CWL_LSB +: 4]};
  assign bmode = mode_reg[DAC_BM_LSB +: 2];
  assign order_il = mode_reg[DAC_ORDER_BIT];
  assign dll_on = mode_reg[DAC_DLL_BIT];

  function automatic logic [3:0] pick_len(input logic [1:0] m,
                                          input logic a12);
    unique case (m)
      DAC_BM_BL8: pick_len = DAC_LEN_BL8;
      DAC_BM_BC4: pick_len = DAC_LEN_BC4;
      DAC_BM_PERCMD: pick_len = a12 ? DAC_LEN_BL8 : DAC_LEN_BC4;
      default: pick_len = DAC_LEN_BL8;
    endcase
  endfunction

  // Burst ordering within the eight-word prefetch group.
  function automatic logic [2:0] beat_col(input logic [2:0] start,
                                          input logic [2:0] beat,
                                          input logic il);
    if (il) begin
      beat_col = start ^ beat;
    end else begin
      beat_col = {start[2] ^ beat[2], start[1:0] + beat[1:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // Command decode and power states
  // ----------------------------------------------------------------
  dac_pwr_t pwr_reg;
  logic [2:0] op;
  logic cmd_ok;
  logic do_act;
  logic do_pre;
  logic do_ref;
  logic [DAC_BANKS-1:0] bank_open_reg;
  logic [DAC_ROW_W-1:0] bank_row_reg [DAC_BANKS];
  logic rd_take;
  logic wr_take;
  logic [3:0] cmd_len;

  assign op = {cmd_s.ras_n, cmd_s.cas_n, cmd_s.we_n};
  assign cmd_ok = ck_pos && !cmd_s.cs_n && cmd_s.cke &&
                  pwr_reg == DAC_PW_ACTIVE;
  assign do_act = cmd_ok && op == DAC_OP_ACT;
  assign do_pre = cmd_ok && op == DAC_OP_PRE;
  assign do_ref = cmd_ok && op == DAC_OP_REF;
  // Column commands to an idle bank, or with the loop off, are dropped.
  assign rd_take = cmd_ok && op == DAC_OP_RD && dll_on &&
                   bank_open_reg[cmd_s.ba];
  assign wr_take = cmd_ok && op == DAC_OP_WR && dll_on &&
                   bank_open_reg[cmd_s.ba];
  assign cmd_len = pick_len(bmode, cmd_s.addr[DAC_BC_BIT]);

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      pwr_reg <= DAC_PW_ACTIVE;
    end else if (ck_pos) begin
      unique case (pwr_reg)
        DAC_PW_ACTIVE: begin
          if (!cmd_s.cke) begin
            if (!cmd_s.cs_n && op == DAC_OP_REF) begin
              pwr_reg <= DAC_PW_SELF;
            end else begin
              pwr_reg <= DAC_PW_DOWN;
            end
          end
        end
        DAC_PW_DOWN, DAC_PW_SELF: begin
          if (cmd_s.cke) begin
            pwr_reg <= DAC_PW_ACTIVE;
          end
        end
        default: pwr_reg <= DAC_PW_ACTIVE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bank state
  // ----------------------------------------------------------------
  logic rd_close;
  logic wr_close;
  logic [2:0] rd_bank_reg;
  logic [2:0] wr_bank_reg;

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      bank_open_reg <= '0;
      for (int b = 0; b < DAC_BANKS; b++) begin
        bank_row_reg[b] <= '0;
      end
    end else begin
      if (rd_close) begin
        bank_open_reg[rd_bank_reg] <= 1'b0;
      end
      if (wr_close) begin
        bank_open_reg[wr_bank_reg] <= 1'b0;
      end
      if (do_pre) begin
        if (cmd_s.addr[DAC_AP_BIT]) begin
          bank_open_reg <= '0;
        end else begin
          bank_open_reg[cmd_s.ba] <= 1'b0;
        end
      end
      if (do_act) begin
        bank_open_reg[cmd_s.ba] <= 1'b1;
        bank_row_reg[cmd_s.ba] <= cmd_s.addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // The row's low bit is kept in the index so that each access reaches
  // the row open in its bank; higher row and column bits alias.
  logic [DAC_DQ_W-1:0] mem [DAC_MEM_WORDS];
  logic [DAC_DQ_W-1:0] wr_buf_reg [DAC_PREFETCH];
  logic [DAC_PREFETCH-1:0] wr_mask_reg;
  logic [2:0] wr_col_reg;
  logic wr_rowb_reg;
  logic [3:0] wr_len_reg;
  logic wr_commit_reg;

  always_ff @(posedge MCLK_IN) begin
    if (wr_commit_reg) begin
      for (int i = 0; i < DAC_PREFETCH; i++) begin
        if (4'(i) < wr_len_reg && !wr_mask_reg[i]) begin
          mem[{wr_bank_reg, wr_rowb_reg,
               beat_col(wr_col_reg, 3'(i), order_il)}]
            <= wr_buf_reg[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read engine
  // ----------------------------------------------------------------
  logic [4:0] rd_cnt_reg;
  logic [2:0] rd_col_reg;
  logic rd_rowb_reg;
  logic [3:0] rd_len_reg;
  logic rd_ap_reg;
  logic rd_burst_reg;
  logic [3:0] rd_beat_reg;
  logic [DAC_DQ_W-1:0] rd_buf_reg [DAC_PREFETCH];

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      rd_cnt_reg <= '0;
      rd_bank_reg <= '0;
      rd_col_reg <= '0;
      rd_rowb_reg <= 1'b0;
      rd_len_reg <= DAC_LEN_BL8;
      rd_ap_reg <= 1'b0;
      rd_close <= 1'b0;
      for (int i = 0; i < DAC_PREFETCH; i++) begin
        rd_buf_reg[i] <= '0;
      end
    end else begin
      rd_close <= 1'b0;
      if (rd_take) begin
        rd_cnt_reg <= rl;
        rd_bank_reg <= cmd_s.ba;
        rd_col_reg <= cmd_s.addr[2:0];
        rd_rowb_reg <= bank_row_reg[cmd_s.ba][0];
        rd_len_reg <= cmd_len;
        rd_ap_reg <= cmd_s.addr[DAC_AP_BIT];
      end else if (ck_pos && rd_cnt_reg != '0) begin
        rd_cnt_reg <= rd_cnt_reg - 5'h1;
      end
      // The whole prefetch group is fetched in one step before the burst.
      if (ck_pos && rd_cnt_reg == 5'h2) begin
        for (int i = 0; i < DAC_PREFETCH; i++) begin
          rd_buf_reg[i] <= mem[{rd_bank_reg, rd_rowb_reg,
                                beat_col(rd_col_reg, 3'(i), order_il)}];
        end
      end
      if (ck_pos && rd_burst_reg && rd_beat_reg == rd_len_reg) begin
        rd_close <= rd_ap_reg;
      end
    end
  end

  // Read strobe rises with even words and falls with odd words.
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      DATA_OUT <= '0;
      rd_burst_reg <= 1'b0;
      rd_beat_reg <= '0;
    end else if (ck_pos && !rd_take && rd_cnt_reg == 5'h2) begin
      DATA_OUT.dqs_oe <= 1'b1;
      DATA_OUT.dqs <= 1'b0;
      DATA_OUT.dqs_n <= 1'b1;
    end else if (ck_pos && !rd_take && rd_cnt_reg == 5'h1) begin
      DATA_OUT.dq <= rd_buf_reg[0];
      DATA_OUT.dq_oe <= 1'b1;
      DATA_OUT.dqs_oe <= 1'b1;
      DATA_OUT.dqs <= 1'b1;
      DATA_OUT.dqs_n <= 1'b0;
      rd_burst_reg <= 1'b1;
      rd_beat_reg <= 4'h1;
    end else if (rd_burst_reg && (ck_pos || ck_neg)) begin
      if (rd_beat_reg == rd_len_reg) begin
        DATA_OUT <= '0;
        rd_burst_reg <= 1'b0;
      end else begin
        DATA_OUT.dq <= rd_buf_reg[rd_beat_reg[2:0]];
        DATA_OUT.dqs <= ck_pos;
        DATA_OUT.dqs_n <= ~ck_pos;
        rd_beat_reg <= rd_beat_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write engine
  // ----------------------------------------------------------------
  logic [4:0] wr_cnt_reg;
  logic wr_ap_reg;
  logic wr_armed_reg;
  logic [3:0] wr_beat_reg;
  logic wr_beat_now;

  // The first word waits for a strobe rise; later words use both edges.
  assign wr_beat_now = wr_armed_reg &&
                       (dqs_rise || (dqs_fall && wr_beat_reg != '0));

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      wr_cnt_reg <= '0;
      wr_bank_reg <= '0;
      wr_col_reg <= '0;
      wr_rowb_reg <= 1'b0;
      wr_len_reg <= DAC_LEN_BL8;
      wr_ap_reg <= 1'b0;
      wr_armed_reg <= 1'b0;
      wr_beat_reg <= '0;
      wr_commit_reg <= 1'b0;
      wr_close <= 1'b0;
      wr_mask_reg <= '0;
      for (int i = 0; i < DAC_PREFETCH; i++) begin
        wr_buf_reg[i] <= '0;
      end
    end else begin
      wr_commit_reg <= 1'b0;
      wr_close <= wr_commit_reg & wr_ap_reg;
      if (wr_take) begin
        wr_cnt_reg <= wl;
        wr_bank_reg <= cmd_s.ba;
        wr_col_reg <= cmd_s.addr[2:0];
        wr_rowb_reg <= bank_row_reg[cmd_s.ba][0];
        wr_len_reg <= cmd_len;
        wr_ap_reg <= cmd_s.addr[DAC_AP_BIT];
      end else if (ck_pos && wr_cnt_reg != '0) begin
        wr_cnt_reg <= wr_cnt_reg - 5'h1;
        if (wr_cnt_reg == 5'h1) begin
          wr_armed_reg <= 1'b1;
          wr_beat_reg <= '0;
          wr_mask_reg <= '0;
        end
      end
      if (wr_beat_now) begin
        wr_buf_reg[wr_beat_reg[2:0]] <= din_s.dq;
        wr_mask_reg[wr_beat_reg[2:0]] <= din_s.dm;
        wr_beat_reg <= wr_beat_reg + 4'h1;
        if (wr_beat_reg + 4'h1 == wr_len_reg) begin
          wr_armed_reg <= 1'b0;
          wr_commit_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic [15:0] ref_cnt_reg;

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      mode_reg <= DAC_MODE_RST;
    end else if (REG_WR_IN && REG_ADDR_IN == DAC_REG_MODE) begin
      mode_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      ref_cnt_reg <= '0;
    end else if (do_ref) begin
      ref_cnt_reg <= ref_cnt_reg + 16'h1;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= '0;
    end else if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        DAC_REG_MODE: REG_RDATA_OUT <= mode_reg;
        DAC_REG_STATUS: begin
          REG_RDATA_OUT <= '0;
          REG_RDATA_OUT[DAC_BANKS-1:0] <= bank_open_reg;
          REG_RDATA_OUT[DAC_ST_PWR_LSB +: 2] <= pwr_reg;
          REG_RDATA_OUT[DAC_ST_RD_BIT] <= rd_burst_reg |
                                          (rd_cnt_reg != '0);
          REG_RDATA_OUT[DAC_ST_WR_BIT] <= wr_armed_reg |
                                          (wr_cnt_reg != '0);
          REG_RDATA_OUT[DAC_ST_DLL_BIT] <= dll_on;
        end
        DAC_REG_REFCNT: REG_RDATA_OUT <= ref_cnt_reg;
        default: REG_RDATA_OUT <= '0;
      endcase
    end else begin
      REG_RDATA_OUT <= '0;
    end
  end

endmodule

//--- verif/dac_core_asserts.sv
// Purpose: Pin and register checks for the memory core.
// Assumes: Pin changes land a few system cycles after a pin clock edge.
// Notes: Burst length is counted in strobe edges while data is driven.

module dac_core_asserts
  import dac_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic CK_IN,
  input wire logic CK_N_IN,
  input wire dac_cmd_t CMD_IN,
  input wire dac_din_t DATA_IN,
  input wire dac_dout_t DATA_OUT,
  input wire logic [DAC_RA_W-1:0] REG_ADDR_IN,
  input wire logic [DAC_RD_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [DAC_RD_W-1:0] REG_RDATA_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  logic [3:0] beats_reg;

  // Counting beats tells a chopped burst from a full one.
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || !DATA_OUT.dq_oe) begin
      beats_reg <= 4'h0;
    end else if (!$past(DATA_OUT.dq_oe) || $changed(DATA_OUT.dqs)) begin
      beats_reg <= beats_reg + 4'h1;
    end
  end

  sequence s_mode_wr;
    REG_WR_IN && REG_ADDR_IN == DAC_REG_MODE;
  endsequence
  sequence s_mode_rd;
    REG_RD_IN && REG_ADDR_IN == DAC_REG_MODE;
  endsequence

  a_idle_quiet: assert property (
    !DATA_OUT.dqs_oe |-> DATA_OUT == 12'h000)
    else $error("outputs not quiet while strobe released");
  a_data_has_strobe: assert property (
    DATA_OUT.dq_oe |-> DATA_OUT.dqs_oe)
    else $error("read data driven without strobe");
  a_strobe_pair: assert property (
    DATA_OUT.dqs_oe |-> DATA_OUT.dqs != DATA_OUT.dqs_n)
    else $error("strobe pair not complementary");
  a_read_preamble: assert property (
    $rose(DATA_OUT.dqs_oe) |-> (!DATA_OUT.dqs && !DATA_OUT.dq_oe)[*8])
    else $error("read preamble too short or not low");
  a_first_beat_rise: assert property (
    $rose(DATA_OUT.dq_oe) |-> DATA_OUT.dqs && $past(DATA_OUT.dqs_oe))
    else $error("first read word not on a strobe rise");
  a_edge_aligned: assert property (
    DATA_OUT.dq_oe && $past(DATA_OUT.dq_oe) && $changed(DATA_OUT.dq)
      |-> $changed(DATA_OUT.dqs))
    else $error("read data changed between strobe edges");
  a_burst_length: assert property (
    $fell(DATA_OUT.dq_oe) |-> beats_reg == 4'h8 || beats_reg == 4'h4)
    else $error("read burst not four or eight beats");
  a_ck_referenced: assert property (
    $changed(DATA_OUT.dqs_oe) |-> $past(CK_IN, 2) != $past(CK_IN, 3)
      || $past(CK_IN, 3) != $past(CK_IN, 4)
      || $past(CK_IN, 4) != $past(CK_IN, 5))
    else $error("strobe enable moved without a pin clock edge");
  a_mode_readback: assert property (
    s_mode_wr ##1 s_mode_rd |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2))
    else $error("mode register did not read back its write");
  a_rdata_stands: assert property (
    !$past(REG_RD_IN) |-> REG_RDATA_OUT == 16'h0000)
    else $error("read data present without a read");
endmodule

//--- verif/dac_ctl_model.sv
// Purpose: Behavioural memory controller driving the pin side.
// Assumes: Pin clock period 160 ns, commands changed on clock falls.
// Notes: Released address, bank and data lines carry inverted values; the mask keeps its last bit.

module dac_ctl_model
  import dac_pkg::*;
(
  output logic ck_out,
  output logic ck_n_out,
  output dac_cmd_t cmd_out,
  output dac_din_t din_out,
  input wire dac_dout_t dout_in
);
  timeunit 1ns;
  timeprecision 1ns;

  assign ck_n_out = ~ck_out;

  // The pin clock runs free; its phase is offset from the system clock.
  initial begin
    ck_out = 1'b0;
    cmd_out = {2'h3, 3'h7, 3'h0, 15'h0};
    din_out = {8'h5a, 3'h1};
    #3;
    forever begin
      #80 ck_out = ~ck_out;
    end
  end

  // One command held across one rise, then deselected.
  task automatic issue(input logic [2:0] op, input logic [2:0] ba,
                       input logic [14:0] a, input logic cs_n,
                       input logic cke);
    @(negedge ck_out);
    cmd_out = {cke, cs_n, op, ba, a};
    @(negedge ck_out);
    cmd_out = {cke, 1'b1, 3'h7, ~ba, ~a};
  endtask

  // Strobe edges sit mid-eye, each word held 80 ns.
  task automatic send(input int wl, input logic [63:0] w,
                      input logic [7:0] m);
    repeat (wl - 1) @(posedge ck_out);
    @(negedge ck_out);
    din_out.dqs = 1'b0;
    din_out.dqs_n = 1'b1;
    @(posedge ck_out);
    for (int i = 0; i < 8; i++) begin
      #40 din_out.dq = w[8*i +: 8];
      din_out.dm = m[i];
      #40 din_out.dqs = ~i[0];
      din_out.dqs_n = i[0];
    end
    #40 din_out.dq = ~din_out.dq;
  endtask

  // Slot 0 is the preamble, 1 to 8 the beats, 9 the edge after.
  task automatic capture(input int rl, output dac_dout_t s [10]);
    repeat (rl - 1) @(posedge ck_out);
    #60 s[0] = dout_in;
    @(posedge ck_out);
    for (int i = 1; i < 10; i++) begin
      if (i > 1) @(ck_out);
      #60 s[i] = dout_in;
    end
  endtask
endmodule

//--- verif/dac_core_test.sv
// Purpose: Self-checking bench for the memory core.
// Assumes: Default mode gives read latency 6, write latency 5.
// Notes: Register strobes are left up until the next bus call.

module dac_core_test
  import dac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk, rst, ck, ck_n, reg_wr, reg_rd;
  dac_cmd_t cmd;
  dac_din_t din;
  dac_dout_t dout;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  int errors = 0;
  int samples_checked = 0;
  localparam logic [63:0] WDAT = 64'h1716151413121110;

  dac_core i_dac_core (.MCLK_IN(mclk), .RST_IN(rst), .CK_IN(ck),
    .CK_N_IN(ck_n), .CMD_IN(cmd), .DATA_IN(din), .DATA_OUT(dout),
    .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr),
    .REG_RD_IN(reg_rd), .REG_RDATA_OUT(reg_rdata));
  dac_ctl_model i_dac_ctl_model (.ck_out(ck), .ck_n_out(ck_n),
    .cmd_out(cmd), .din_out(din), .dout_in(dout));

  initial begin
    mclk = 1'b0;
    forever begin
      #5 mclk = ~mclk;
    end
  end

  task automatic bus(input logic w, input logic r, input logic [3:0] a,
                     input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask

  task automatic check_reg(input logic [3:0] a, input logic [15:0] exp);
    bus(1'b0, 1'b1, a, 16'h0000);
    bus(1'b0, 1'b0, a, 16'h0000);
    #1;
    samples_checked++;
    if (reg_rdata !== exp) begin
      errors++;
      $display("CHECK FAILED reg %h expected %h seen %h", a, exp, reg_rdata);
    end
  endtask

  task automatic check_burst(input int rl, input logic [63:0] w,
                             input int n);
    dac_dout_t s [10];
    dac_dout_t exp;
    i_dac_ctl_model.capture(rl, s);
    for (int i = 0; i < 10; i++) begin
      exp = 12'h000;
      if (i == 0 && n > 0) exp = 12'h003;
      else if (i > 0 && i <= n) exp = {w[8*i-8 +: 8], 1'b1, i[0], ~i[0], 1'b1};
      samples_checked++;
      if (s[i] !== exp) begin
        errors++;
        $display("CHECK FAILED slot %0d expected %h seen %h", i, exp, s[i]);
      end
    end
  endtask

  task automatic close_out;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    errors++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 22'h0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    check_reg(DAC_REG_MODE, DAC_MODE_RST);
    check_reg(DAC_REG_STATUS, 16'h1000);
    check_reg(4'h7, 16'h0000);
    bus(1'b1, 1'b0, DAC_REG_STATUS, 16'h00ff);
    check_reg(DAC_REG_STATUS, 16'h1000);
    i_dac_ctl_model.issue(DAC_OP_ACT, 3'h2, 15'h0001, 1'b0, 1'b1);
    check_reg(DAC_REG_STATUS, 16'h1004);
    i_dac_ctl_model.issue(DAC_OP_WR, 3'h2, 15'h1000, 1'b0, 1'b1);
    i_dac_ctl_model.send(5, WDAT, 8'h00);
    i_dac_ctl_model.issue(DAC_OP_RD, 3'h2, 15'h1003, 1'b0, 1'b1);
    check_burst(6, 64'h1615141712111013, 8);
    i_dac_ctl_model.issue(DAC_OP_WR, 3'h2, 15'h1000, 1'b0, 1'b1);
    i_dac_ctl_model.send(5, 64'h2727272727272710, 8'hfe);
    bus(1'b1, 1'b0, DAC_REG_MODE, 16'hc256);
    check_reg(DAC_REG_MODE, 16'hc256);
    i_dac_ctl_model.issue(DAC_OP_RD, 3'h2, 15'h1003, 1'b0, 1'b1);
    check_burst(8, 64'h1415161710111213, 8);
    bus(1'b1, 1'b0, DAC_REG_MODE, 16'ha056);
    check_reg(DAC_REG_MODE, 16'ha056);
    i_dac_ctl_model.issue(DAC_OP_RD, 3'h2, 15'h1000, 1'b0, 1'b1);
    check_burst(6, WDAT, 8);
    i_dac_ctl_model.issue(DAC_OP_RD, 3'h2, 15'h0400, 1'b0, 1'b1);
    check_burst(6, WDAT, 4);
    repeat (20) @(posedge mclk);
    check_reg(DAC_REG_STATUS, 16'h1000);
    i_dac_ctl_model.issue(DAC_OP_RD, 3'h2, 15'h1000, 1'b0, 1'b1);
    check_burst(6, WDAT, 0);
    i_dac_ctl_model.issue(DAC_OP_ACT, 3'h2, 15'h0001, 1'b0, 1'b1);
    i_dac_ctl_model.issue(DAC_OP_RD, 3'h2, 15'h1000, 1'b1, 1'b1);
    check_burst(6, WDAT, 0);
    bus(1'b1, 1'b0, DAC_REG_MODE, 16'h9056);
    check_reg(DAC_REG_MODE, 16'h9056);
    i_dac_ctl_model.issue(DAC_OP_RD, 3'h2, 15'h1000, 1'b0, 1'b1);
    check_burst(6, WDAT, 4);
    i_dac_ctl_model.issue(DAC_OP_ACT, 3'h5, 15'h0000, 1'b0, 1'b1);
    check_reg(DAC_REG_STATUS, 16'h1024);
    i_dac_ctl_model.issue(DAC_OP_PRE, 3'h2, 15'h0000, 1'b0, 1'b1);
    check_reg(DAC_REG_STATUS, 16'h1020);
    i_dac_ctl_model.issue(DAC_OP_PRE, 3'h0, 15'h0400, 1'b0, 1'b1);
    check_reg(DAC_REG_STATUS, 16'h1000);
    i_dac_ctl_model.issue(DAC_OP_REF, 3'h0, 15'h0000, 1'b0, 1'b1);
    check_reg(DAC_REG_REFCNT, 16'h0001);
    i_dac_ctl_model.issue(DAC_OP_REF, 3'h0, 15'h0000, 1'b0, 1'b0);
    check_reg(DAC_REG_STATUS, 16'h1200);
    i_dac_ctl_model.issue(3'h7, 3'h0, 15'h0000, 1'b1, 1'b1);
    check_reg(DAC_REG_STATUS, 16'h1000);
    i_dac_ctl_model.issue(3'h7, 3'h0, 15'h0000, 1'b1, 1'b0);
    check_reg(DAC_REG_STATUS, 16'h1100);
    i_dac_ctl_model.issue(3'h7, 3'h0, 15'h0000, 1'b1, 1'b1);
    bus(1'b1, 1'b0, DAC_REG_MODE, 16'h0056);
    check_reg(DAC_REG_STATUS, 16'h0000);
    i_dac_ctl_model.issue(DAC_OP_ACT, 3'h2, 15'h0001, 1'b0, 1'b1);
    i_dac_ctl_model.issue(DAC_OP_RD, 3'h2, 15'h1000, 1'b0, 1'b1);
    check_burst(6, WDAT, 0);
    close_out();
  end
endmodule

bind dac_core dac_core_asserts i_dac_core_asserts (
  .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .CK_IN(CK_IN), .CK_N_IN(CK_N_IN),
  .CMD_IN(CMD_IN), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
  .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT));
